// *** rtl/mfcs_pkg.sv ***
/*
 meter_fault_channel_select constants: register map, field positions, reset values,
 thresholds and timing counts derived from the 40 MHz core clock.
 assumes: samples are signed two's complement, full scale magnitude 2**15.
*/
package mfcs_pkg;
   // core clock, 40 MHz
   localparam int unsigned CLK_HZ = 32'h0262_5A00;
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 64;

   // times in their own unit
   localparam int unsigned QUAL_S = 32'h1;
   localparam int unsigned FILT_TAU_S = 32'h3;
   localparam int unsigned MN_WIN_MS = 32'h19;
   localparam int unsigned SLOW_PW_MS = 32'h64;
   localparam int unsigned CALIB_PW_US = 32'h5A;

   // cycle counts
   localparam int unsigned FILT_SHIFT = 32'h8;
   localparam int unsigned QUAL_CYC = QUAL_S * CLK_HZ;
   localparam int unsigned FILT_TICK_CYC = (FILT_TAU_S * CLK_HZ) >> FILT_SHIFT;
   localparam int unsigned MN_WIN_CYC = MN_WIN_MS * (CLK_HZ / 32'h3E8);
   localparam int unsigned SLOW_PW_CYC = SLOW_PW_MS * (CLK_HZ / 32'h3E8);
   localparam int unsigned CALIB_PW_CYC = CALIB_PW_US * (CLK_HZ / 32'h000F_4240);

   // magnitudes and thresholds
   localparam logic [31:0] FS_MAG = 32'h0000_8000;
   localparam logic [31:0] LIGHT_TH = (FS_MAG * 32'h3) / 32'h3E8;
   localparam logic [31:0] MN_PEAK_TH = (FS_MAG * 32'h9) / 32'h64;
   localparam int unsigned MISMATCH_SHIFT = 32'h4;

   // dc full scale product 2**30 per cycle gives 0.68 Hz slow rate at rate select 0
   localparam logic [63:0] SLOW_TH = ((64'(CLK_HZ)) << 30) * 64'h19 / 64'h11;

   // calibration ratio exponents
   localparam logic [3:0] RATIO_128 = 4'h7;
   localparam logic [3:0] RATIO_64 = 4'h6;
   localparam logic [3:0] RATIO_32 = 4'h5;
   localparam logic [3:0] RATIO_16 = 4'h4;
   localparam logic [3:0] RATIO_2048 = 4'hB;

   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PHASE_AVG = 8'h08;
   localparam logic [7:0] ADDR_NEUTRAL_AVG = 8'h0C;
   localparam logic [4:0] CTRL_RESET = 5'h01;
   localparam int CTRL_PULSE_EN = 0;
   localparam int CTRL_SEL_REG = 1;
   localparam int CTRL_SCF = 2;
   localparam int CTRL_RS_LO = 3;
   localparam int CTRL_RS_HI = 4;
   localparam int ST_FAULT = 0;
   localparam int ST_MISMATCH = 1;
   localparam int ST_MISSING = 2;
   localparam int ST_NEUTRAL = 3;
   localparam int ST_LIGHT = 4;
endpackage

// *** rtl/mfcs_avg.sv ***
/*
 mfcs_avg: rectifying leaky averager for one current channel.
 assumes: tick_i is a one-cycle strobe from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module mfcs_avg #(
   parameter int SW = 16,
   parameter int K = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // sample path
   input wire logic tick_i,
   input wire logic signed [SW-1:0] sample_i,
   output logic [SW-1:0] avg_o
);
   logic [SW+K-1:0] acc_r;
   logic [SW+K-1:0] acc_nxt;
   logic [SW-1:0] mag;

   // -min fits as unsigned in SW bits
   assign mag = sample_i[SW-1] ? SW'(-sample_i) : SW'(sample_i);
   // time constant is 2**K ticks; the leak term keeps the sum bounded
   assign acc_nxt = acc_r + (SW+K)'(mag) - (acc_r >> K);

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_r <= '0;
         avg_o <= '0;
      end else if (tick_i) begin
         acc_r <= acc_nxt;
         avg_o <= acc_nxt[SW+K-1:K];
      end
   end
endmodule // mfcs_avg
`default_nettype wire

// *** rtl/mfcs_top.sv ***
/*
 mfcs_top: fault-tolerant channel select, missing-neutral detection and pulse
 scaling for an energy meter, with an APB register slave.
 assumes: current, voltage and backup gain samples come from logic on clk_i;
 the three select pins are asynchronous and are synchronised here.
*/
// Design decisions made here: the address map and the APB slave port.
// Notes on behaviour
// RULE_01 - calib rate is 16..128 times slow rate, 2048 for scale 0 rates 11
// RULE_02 - slow maximum rate doubles per rate select step
// RULE_03 - full-scale ac gives half the maximum rate of full-scale dc
// RULE_04 - mismatch fault when currents differ by more than one sixteenth
// RULE_05 - during mismatch, keep billing from the larger current
// RULE_06 - start on phase; after about one second alarm, swap if neutral larger
// RULE_07 - no mismatch detection below 0.3 percent of full scale
// RULE_08 - inactive below 93.75 percent of larger active: alarm, no swap
// RULE_09 - currents are averaged, alarm follows with about three seconds delay
// RULE_10 - alarm never depends on slow pulse activity
// RULE_11 - neutral exceeding phase by a sixteenth: alarm, swap to neutral
// RULE_12 - swap back only when phase exceeds neutral by a sixteenth of phase
// RULE_13 - alarm drops once phase is within a sixteenth of neutral
// RULE_14 - alarm held high while neutral is missing
// RULE_15 - missing neutral bills on current scaled by backup gain level
// RULE_16 - missing-neutral detection window suits 45 to 55 Hz lines
// RULE_17 - missing neutral pulses track ampere-hours, alarm high
// RULE_18 - enter missing neutral on peak below 9 percent or no crossing
// RULE_19 - leave missing neutral when peak above 9 percent and a crossing seen
// RULE_20 - alarm is mismatch fault or missing neutral
`timescale 1ns/100ps
`default_nettype none
module mfcs_top
   import mfcs_pkg::*;
#(
   parameter int SW = mfcs_pkg::SAMPLE_W,
   parameter int unsigned QUAL_CYC_P = mfcs_pkg::QUAL_CYC,
   parameter int unsigned FILT_TICK_P = mfcs_pkg::FILT_TICK_CYC,
   parameter int unsigned MN_WIN_P = mfcs_pkg::MN_WIN_CYC,
   parameter int unsigned SLOW_PW_P = mfcs_pkg::SLOW_PW_CYC,
   parameter int unsigned CALIB_PW_P = mfcs_pkg::CALIB_PW_CYC,
   parameter logic [63:0] SLOW_TH_P = mfcs_pkg::SLOW_TH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // sampled inputs
   input wire logic signed [SW-1:0] phase_current_in_i,
   input wire logic signed [SW-1:0] neutral_current_in_i,
   input wire logic signed [SW-1:0] line_voltage_pos_i,
   input wire logic signed [SW-1:0] line_voltage_neg_i,
   input wire logic [SW-1:0] backup_gain_level_i,
   // select pins
   input wire logic calib_scale_sel_i,
   input wire logic rate_sel_lo_i,
   input wire logic rate_sel_hi_i,
   // outputs
   output logic calib_pulse_out_o,
   output logic slow_pulse_a_o,
   output logic slow_pulse_b_o,
   output logic fault_o
);
   import mfcs_pkg::*;

   function automatic logic [3:0] ratio_log2(input logic [2:0] code);
      case (code)
         3'b100: ratio_log2 = RATIO_128;
         3'b000: ratio_log2 = RATIO_64;
         3'b101: ratio_log2 = RATIO_64;
         3'b001: ratio_log2 = RATIO_32;
         3'b110: ratio_log2 = RATIO_32;
         3'b010: ratio_log2 = RATIO_16;
         3'b111: ratio_log2 = RATIO_16;
         3'b011: ratio_log2 = RATIO_2048;
         default: ratio_log2 = RATIO_64;
      endcase
   endfunction

   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic [4:0] ctrl_r;
   logic [2:0] sel_code;
   logic [31:0] tick_cnt_r;
   logic tick;
   logic [SW-1:0] pa;
   logic [SW-1:0] na;
   logic [SW-1:0] act;
   logic [SW-1:0] ina;
   logic [SW-1:0] larger;
   logic [SW-1:0] diff;
   logic light;
   logic mm_raw;
   logic swap_raw;
   logic [31:0] qual_cnt_r;
   logic qual_done;
   logic mismatch_r;
   logic mismatch_nxt;
   logic sel_neutral_r;
   logic fault_r;
   logic signed [SW:0] v_diff;
   logic [SW:0] v_mag;
   logic [SW:0] peak_cur;
   logic zc_cur;
   logic [SW:0] peak_r;
   logic zc_r;
   logic sign_prev_r;
   logic [31:0] win_cnt_r;
   logic win_end;
   logic missing_r;
   logic missing_nxt;
   logic signed [SW-1:0] i_sel;
   logic [SW-1:0] i_mag;
   logic signed [2*SW:0] prod_s;
   logic [2*SW-1:0] pwr;
   logic [ACC_W-1:0] inc;
   logic [ACC_W-1:0] calib_th;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_sum;
   logic calib_evt;
   logic slow_evt;
   logic [11:0] cal_cnt_r;
   logic [11:0] ratio_m1;
   logic [31:0] cal_pw_r;
   logic [31:0] cal_pw_nxt;
   logic [31:0] slow_pw_r;
   logic [31:0] slow_pw_nxt;
   logic pulse_en;
   logic apb_setup;
   logic apb_wr;
   logic addr_ok;
   logic [31:0] rd_mux;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // select pins: two flops each, only the second is read
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
               pin_s1_r[g] <= 1'b0;
               pin_s2_r[g] <= 1'b0;
            end else begin
               pin_s1_r[g] <= (g == 0) ? rate_sel_lo_i : (g == 1) ? rate_sel_hi_i
                  : calib_scale_sel_i;
               pin_s2_r[g] <= pin_s1_r[g];
            end
         end
      end
   endgenerate

   assign sel_code = ctrl_r[CTRL_SEL_REG] ?
      {ctrl_r[CTRL_SCF], ctrl_r[CTRL_RS_HI], ctrl_r[CTRL_RS_LO]} : {pin_s2_r[2], pin_s2_r[1:0]};
   assign pulse_en = ctrl_r[CTRL_PULSE_EN];

   // averaging of both currents before comparing
   assign tick = (tick_cnt_r == FILT_TICK_P - 1); // RULE_09
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || tick) tick_cnt_r <= '0;
      else tick_cnt_r <= tick_cnt_r + 32'h1;
   end

   mfcs_avg #(.SW(SW), .K(FILT_SHIFT)) u_avg_phase (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
      .sample_i(phase_current_in_i), .avg_o(pa)
   );
   mfcs_avg #(.SW(SW), .K(FILT_SHIFT)) u_avg_neutral (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
      .sample_i(neutral_current_in_i), .avg_o(na)
   );

   // mismatch decision on averaged magnitudes
   assign act = sel_neutral_r ? na : pa;
   assign ina = sel_neutral_r ? pa : na;
   assign larger = (pa > na) ? pa : na;
   assign diff = (pa > na) ? (pa - na) : (na - pa);
   assign light = (32'(larger) < LIGHT_TH); // RULE_07
   assign mm_raw = !light && (diff > (larger >> MISMATCH_SHIFT)); // RULE_04 RULE_08 RULE_13
   // one sixteenth of the larger one keeps swap and swap-back apart, no chatter
   assign swap_raw = !light && (ina > act)
      && ((ina - act) > (ina >> MISMATCH_SHIFT)); // RULE_11 RULE_12
   assign qual_done = mm_raw && (qual_cnt_r == QUAL_CYC_P - 1); // RULE_06
   assign mismatch_nxt = mm_raw && (mismatch_r || qual_done); // RULE_13

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         qual_cnt_r <= '0;
         mismatch_r <= 1'b0;
         sel_neutral_r <= 1'b0; // RULE_06
      end else begin
         if (!mm_raw) qual_cnt_r <= '0;
         else if (!qual_done) qual_cnt_r <= qual_cnt_r + 32'h1;
         mismatch_r <= mismatch_nxt;
         if (qual_done && swap_raw) sel_neutral_r <= ~sel_neutral_r; // RULE_11 RULE_12
      end
   end

   // missing-neutral watch over a window longer than one 45 Hz cycle
   assign v_diff = $signed({line_voltage_pos_i[SW-1], line_voltage_pos_i})
      - $signed({line_voltage_neg_i[SW-1], line_voltage_neg_i});
   assign v_mag = v_diff[SW] ? (SW+1)'(-v_diff) : (SW+1)'(v_diff);
   assign peak_cur = (v_mag > peak_r) ? v_mag : peak_r;
   assign zc_cur = zc_r || (v_diff[SW] != sign_prev_r);
   assign win_end = (win_cnt_r == MN_WIN_P - 1); // RULE_16
   assign missing_nxt = !win_end ? missing_r
      : ((32'(peak_cur) < MN_PEAK_TH) || !zc_cur) ? 1'b1 // RULE_18
      : ((32'(peak_cur) > MN_PEAK_TH) && zc_cur) ? 1'b0 : missing_r; // RULE_19

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         win_cnt_r <= '0;
         peak_r <= '0;
         zc_r <= 1'b0;
         sign_prev_r <= 1'b0;
         missing_r <= 1'b0;
      end else begin
         win_cnt_r <= win_end ? '0 : win_cnt_r + 32'h1;
         peak_r <= win_end ? '0 : peak_cur;
         zc_r <= win_end ? 1'b0 : zc_cur;
         sign_prev_r <= v_diff[SW];
         missing_r <= missing_nxt;
      end
   end

   // alarm from detectors only, no pulse logic feeds it
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) fault_r <= 1'b0;
      else fault_r <= mismatch_r | missing_r; // RULE_20 RULE_14 RULE_10
   end
   assign fault_o = fault_r;

   // billing power: instantaneous product, so ac averages to half of dc
   assign i_sel = sel_neutral_r ? neutral_current_in_i : phase_current_in_i; // RULE_05
   assign i_mag = i_sel[SW-1] ? SW'(-i_sel) : SW'(i_sel);
   assign prod_s = i_sel * v_diff; // RULE_03
   // reverse power is not billed; negative products clip to zero
   assign pwr = missing_r ? (2*SW)'(i_mag * backup_gain_level_i) // RULE_15 RULE_17
      : (prod_s[2*SW] ? '0 : prod_s[2*SW-1:0]);
   assign inc = ACC_W'(pwr) << sel_code[1:0]; // RULE_02
   assign calib_th = SLOW_TH_P >> ratio_log2(sel_code); // RULE_01
   assign acc_sum = acc_r + inc;
   assign calib_evt = pulse_en && (acc_sum >= calib_th);
   assign ratio_m1 = (12'h001 << ratio_log2(sel_code)) - 12'h001;
   // a select change mid-count may leave the count above the new ratio
   assign slow_evt = calib_evt && (cal_cnt_r >= ratio_m1); // RULE_01

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_r <= '0;
         cal_cnt_r <= '0;
      end else if (pulse_en) begin
         acc_r <= calib_evt ? acc_sum - calib_th : acc_sum;
         if (slow_evt) cal_cnt_r <= '0;
         else if (calib_evt) cal_cnt_r <= cal_cnt_r + 12'h001;
      end
   end

   // pulse stretchers; a new event restarts the width
   assign cal_pw_nxt = calib_evt ? CALIB_PW_P : (cal_pw_r != 0) ? cal_pw_r - 32'h1 : '0;
   assign slow_pw_nxt = slow_evt ? SLOW_PW_P : (slow_pw_r != 0) ? slow_pw_r - 32'h1 : '0;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cal_pw_r <= '0;
         slow_pw_r <= '0;
         calib_pulse_out_o <= 1'b0;
         slow_pulse_a_o <= 1'b0;
         slow_pulse_b_o <= 1'b0;
      end else begin
         cal_pw_r <= cal_pw_nxt;
         slow_pw_r <= slow_pw_nxt;
         calib_pulse_out_o <= (cal_pw_nxt != 0);
         slow_pulse_a_o <= (slow_pw_nxt != 0);
         slow_pulse_b_o <= (slow_pw_nxt != 0);
      end
   end

   // apb slave, zero wait states
   assign apb_setup = psel_i && !penable_i;
   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign addr_ok = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS)
      || (paddr_i == ADDR_PHASE_AVG) || (paddr_i == ADDR_NEUTRAL_AVG);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;
   assign rd_mux = (paddr_i == ADDR_CTRL) ? {27'h0, ctrl_r}
      : (paddr_i == ADDR_STATUS) ? {27'h0, light, sel_neutral_r, missing_r, mismatch_r, fault_r}
      : (paddr_i == ADDR_PHASE_AVG) ? 32'(pa)
      : (paddr_i == ADDR_NEUTRAL_AVG) ? 32'(na) : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ctrl_r <= CTRL_RESET;
         prdata_o <= '0;
      end else begin
         if (apb_setup && !pwrite_i) prdata_o <= rd_mux;
         if (apb_wr && (paddr_i == ADDR_CTRL) && pstrb_i[0]) ctrl_r <= pwdata_i[4:0];
      end
   end

   // checks
   sequence mm_held_s;
      mm_raw && (qual_cnt_r == QUAL_CYC_P - 1);
   endsequence

   alarm_missing_a: assert property (missing_r |=> fault_o) // RULE_14
      else $error("alarm low while neutral missing");
   alarm_or_a: assert property (fault_o == $past(mismatch_r | missing_r)) // RULE_20
      else $error("alarm not the or of the two detectors");
   light_quiet_a: assert property (light |=> !$rose(mismatch_r)) // RULE_07
      else $error("mismatch raised under light load");
   fault_qual_a: assert property ($rose(mismatch_r) |-> $past(qual_done)) // RULE_06
      else $error("mismatch raised before qualification time");
   fault_drop_a: assert property (mismatch_r && !mm_raw |=> !mismatch_r) // RULE_13
      else $error("alarm did not drop when currents agree");
   no_swap_a: assert property (mm_raw && (act >= ina) |=> $stable(sel_neutral_r)) // RULE_08
      else $error("swap while active input is larger");
   swap_cause_a: assert property (mm_held_s ##0 swap_raw // RULE_11
      |=> sel_neutral_r != $past(sel_neutral_r))
      else $error("qualified swap not taken");
   swap_back_a: assert property ($fell(sel_neutral_r) |-> $past(pa > na)) // RULE_12
      else $error("swap back while phase not larger");
   slow_ratio_a: assert property ($rose(slow_pulse_a_o) |-> calib_pulse_out_o) // RULE_01
      else $error("slow pulse without a calib pulse");
   slow_width_a: assert property (slow_evt |=> slow_pulse_a_o && slow_pulse_b_o) // RULE_02
      else $error("slow pulse not started");
   mn_enter_a: assert property (win_end && (32'(peak_cur) < MN_PEAK_TH) |=> missing_r) // RULE_18
      else $error("low peak did not enter missing neutral");
   mn_leave_a: assert property (win_end && (32'(peak_cur) > MN_PEAK_TH) && zc_cur
      |=> !missing_r) // RULE_19
      else $error("good voltage did not leave missing neutral");
   apb_err_a: assert property (psel_i && penable_i && !addr_ok |-> pslverr_o && pready_o)
      else $error("unmapped access not flagged");
endmodule // mfcs_top
`default_nettype wire

// *** testbench/mfcs_pulse_counter.sv ***
/*
 mfcs_pulse_counter: far-side pulse counter, as a metering controller would see it.
 assumes: pulse lines are registered on clk_i and active high.
*/
`timescale 1ns/100ps
`default_nettype none
module mfcs_pulse_counter (
   // clock
   input wire logic clk_i,
   // pulse lines
   input wire logic calib_i,
   input wire logic slow_a_i,
   input wire logic slow_b_i,
   // counts
   output int ratio_o = 0,
   output int period_o = 0,
   output int n_slow_o = 0,
   output int n_calib_o = 0,
   output logic ab_split_o = 1'b0
);
   logic calib_d = 1'b0;
   logic slow_d = 1'b0;
   int cnt = 0;
   int cyc = 0;
   wire logic calib_rise = calib_i & ~calib_d;
   always @(posedge clk_i) begin
      calib_d <= calib_i;
      slow_d <= slow_a_i;
      cyc <= cyc + 1;
      n_calib_o <= n_calib_o + int'(calib_rise);
      if (slow_a_i !== slow_b_i) ab_split_o <= 1'b1;
      // slow edge shares its cycle with the last calib edge
      if (slow_a_i && !slow_d) begin
         ratio_o <= cnt + int'(calib_rise);
         period_o <= cyc;
         cyc <= 1;
         n_slow_o <= n_slow_o + 1;
         cnt <= 0;
      end else begin
         cnt <= cnt + int'(calib_rise);
      end
   end
endmodule // mfcs_pulse_counter
`default_nettype wire

// *** testbench/testbench.sv ***
/*
 testbench: scenario tasks for mfcs_top with a far-side pulse counter.
 assumes: 40 MHz clock, shortened counts set by the parameters below.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import mfcs_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, scale, rlo, rhi;
   logic pready, pslverr, err, calib, sa, sb, fault, ab_split;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic signed [15:0] ph, ne, vp, vn;
   logic [15:0] gain, vcnt;
   logic [1:0] vmode;
   int n_fail, samples_checked, cyc, ratio, period, n_slow, n_calib, p1;

   // shortened counts so that every scenario fits the run
   localparam int unsigned T_QUAL = 32'h0000_0014;
   localparam int unsigned T_TICK = 32'h0000_0002;
   localparam int unsigned T_WIN = 32'h0000_0040;
   localparam int unsigned T_SLOW_PW = 32'h0000_000A;
   localparam int unsigned T_CALIB_PW = 32'h0000_0002;
   localparam logic [63:0] T_SLOW_TH = 64'h0000_0000_0400_0000;

   mfcs_top #(.QUAL_CYC_P(T_QUAL), .FILT_TICK_P(T_TICK), .MN_WIN_P(T_WIN),
      .SLOW_PW_P(T_SLOW_PW), .CALIB_PW_P(T_CALIB_PW), .SLOW_TH_P(T_SLOW_TH)) DUT (
      .clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .phase_current_in_i(ph), .neutral_current_in_i(ne), .line_voltage_pos_i(vp),
      .line_voltage_neg_i(vn), .backup_gain_level_i(gain),
      .calib_scale_sel_i(scale), .rate_sel_lo_i(rlo), .rate_sel_hi_i(rhi),
      .calib_pulse_out_o(calib), .slow_pulse_a_o(sa), .slow_pulse_b_o(sb), .fault_o(fault));

   mfcs_pulse_counter u_cnt (.clk_i(clk), .calib_i(calib), .slow_a_i(sa), .slow_b_i(sb),
      .ratio_o(ratio), .period_o(period), .n_slow_o(n_slow), .n_calib_o(n_calib),
      .ab_split_o(ab_split));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // line voltage: off, square wave with crossings, or dc with none
   always @(posedge clk) begin
      vcnt <= vcnt + 16'h0001;
      // negative half split across both pins to exercise the difference
      vp <= (vmode == 2'h1 && vcnt[3]) ? 16'shEC78 : ((vmode != 2'h0) ? 16'sh2710 : 16'sh0000);
      vn <= (vmode == 2'h1 && vcnt[3]) ? 16'sh1388 : 16'sh0000;
   end

   always @(posedge clk) begin
      cyc++;
      // scenarios need about 66000 cycles
      if (cyc == 90000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // setup, then access held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // only the run's own timeout ends a wait that never completes
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_i(input logic [15:0] p, input logic [15:0] n, input int w);
      ph <= p;
      ne <= n;
      repeat (w) @(posedge clk);
   endtask

   task automatic pulse_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask

   task automatic wait_slow(input int k);
      int s0;
      s0 = n_slow;
      for (int n = 0; n < 40000 && n_slow < s0 + k; n++) @(posedge clk);
   endtask

   task automatic t_fault();
      set_i(16'h003C, 16'h0000, 3000);
      check(fault === 1'b0, "fault at light load");
      set_i(16'h2710, 16'h1F40, 4000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(fault === 1'b1 && rd[ST_MISMATCH] === 1'b1, "mismatch not flagged");
      check(rd[ST_NEUTRAL] === 1'b0, "swapped while active larger");
      set_i(16'h2710, 16'h2EE0, 4000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(fault === 1'b1 && rd[ST_NEUTRAL] === 1'b1, "no swap to neutral");
      set_i(16'h2CEC, 16'h2EE0, 4000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(fault === 1'b0 && rd[ST_NEUTRAL] === 1'b1, "alarm kept or early swap");
      set_i(16'h30D4, 16'h2EE0, 4000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[ST_NEUTRAL] === 1'b1, "swapped back inside margin");
      set_i(16'h32C8, 16'h2EE0, 4000);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[ST_NEUTRAL] === 1'b0 && fault === 1'b1, "no return to phase");
   endtask

   task automatic t_missing();
      set_i(16'h1F40, 16'h1F40, 4000);
      check(fault === 1'b0, "fault with equal currents");
      vmode <= 2'h0;
      repeat (300) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(fault === 1'b1 && rd[ST_MISSING] === 1'b1, "low peak not missing");
      vmode <= 2'h1;
      repeat (300) @(posedge clk);
      check(fault === 1'b0, "normal mode not restored");
      vmode <= 2'h2;
      repeat (300) @(posedge clk);
      check(fault === 1'b1, "no crossing not missing");
      vmode <= 2'h0;
   endtask

   // calib period of four cycles for every code, in missing mode
   task automatic t_codes();
      int exp_r, s;
      for (int c = 0; c < 8; c++) begin
         s = c & 3;
         exp_r = (c == 3) ? 2048 : (((c & 4) != 0) ? 128 : 64) >> s;
         set_i(16'(1 << (16 - $clog2(exp_r) - s)), 16'(1 << (16 - $clog2(exp_r) - s)), 1);
         scale <= c[2];
         rhi <= c[1];
         rlo <= c[0];
         pulse_reset();
         wait_slow(2);
         check(ratio === exp_r, "calib to slow ratio");
         check(fault === 1'b1, "alarm low in missing mode");
      end
      check(ab_split === 1'b0, "slow outputs differ");
   endtask

   task automatic t_gain_reg();
      {scale, rhi, rlo} <= 3'h0;
      set_i(16'h0400, 16'h0400, 1);
      pulse_reset();
      wait_slow(2);
      p1 = period;
      gain <= 16'h0200;
      wait_slow(2);
      check(period * 2 <= p1 + 4 && period * 2 + 4 >= p1, "rate not scaled by gain");
      gain <= 16'h0100;
      {scale, rhi, rlo} <= 3'h4;
      set_i(16'h0004, 16'h0004, 1);
      apb(1'b1, ADDR_CTRL, 32'h0000_001B);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd === 32'h0000_001B, "ctrl readback");
      wait_slow(2);
      check(ratio === 2048, "ratio from register selects");
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      repeat (10) @(posedge clk);
      p1 = n_calib;
      repeat (400) @(posedge clk);
      check(n_calib === p1, "pulses while disabled");
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, scale, rlo, rhi} = 7'h00;
      {paddr, pwdata, ph, ne, vcnt} = '0;
      gain = 16'h0100;
      pstrb = 4'hF;
      vmode = 2'h1;
      {n_fail, samples_checked, cyc} = '0;
      repeat (20) @(posedge clk);
      check({calib, sa, sb, fault} === 4'h0, "outputs during reset");
      rst_n <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd === 32'h0000_0001 && err === 1'b0, "ctrl reset value");
      pstrb <= 4'h0;
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      pstrb <= 4'hF;
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd === 32'h0000_0001, "write with lane 0 masked landed");
      apb(1'b0, 8'h10, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped read");
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[ST_NEUTRAL] === 1'b0, "start on neutral");
      t_fault();
      t_missing();
      t_codes();
      t_gain_reg();
      complete_run();
   end
endmodule // testbench
`default_nettype wire
